/* File: logic/bcfg_pkg.sv */
// Purpose: Shared constants for the regulator configuration register bank
// Assumes: 8-bit register addresses and data
// Notes: Offsets are the serial register addresses
package bcfg_pkg;
  localparam logic [7:0] BCFG_OFS_CUR_THRESH = 8'h05;
  localparam logic [7:0] BCFG_OFS_DISCHARGE = 8'h06;
  localparam logic [7:0] BCFG_OFS_RESTORE = 8'h07;
  localparam logic [3:0] BCFG_RST_CODE = 4'hf;
  localparam logic BCFG_RST_DIS_EN = 1'b0;
  localparam logic [1:0] BCFG_RST_DIS_SEL = 2'h0;
  localparam logic [11:0] BCFG_RST_MA = 12'h866;
  localparam logic [7:0] BCFG_RST_RDATA = 8'h00;
  localparam logic BCFG_RST_REGULATE = 1'b0;
  localparam logic [7:0] BCFG_RESTORE_KEY = 8'h60;
  localparam int BCFG_CODE_LSB = 0;
  localparam int BCFG_DIS_EN_BIT = 2;
  localparam int BCFG_DIS_SEL_LSB = 0;
  localparam logic [11:0] BCFG_PEAK_CURRENT_CODE_BASE_MA = 12'd530;
  localparam logic [11:0] BCFG_PEAK_CURRENT_CODE_STEP_MA = 12'd108;
  localparam logic [1:0] BCFG_SEL_OPEN = 2'h0;
  localparam logic [1:0] BCFG_SEL_200_OHM = 2'h1;
  localparam logic [1:0] BCFG_SEL_100_OHM = 2'h2;
  localparam logic [1:0] BCFG_SEL_50_OHM = 2'h3;
  typedef enum logic [0:0] {
    BCFG_DIS_IDLE = 1'b0,
    BCFG_DIS_ACTIVE = 1'b1
  } bcfg_dis_state_e;
endpackage : bcfg_pkg

/* File: logic/bcfg_dis_if.sv */
// Purpose: Signals between the register bank and the discharge control
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ps
interface bcfg_dis_if;
  logic discharge_en;
  logic reg_enable;
  logic vout_falling;
  logic pulldown_active;
  modport ctl (output discharge_en, output reg_enable, output vout_falling, input pulldown_active);
  modport dis (input discharge_en, input reg_enable, input vout_falling, output pulldown_active);
endinterface : bcfg_dis_if

/* File: logic/bcfg_discharge.sv */
// Purpose: Output pull-down control from enable fall and falling output
// Assumes: Inputs synchronous to the clock
// Notes: Pull-down held from the enable fall until enable returns or the discharge enable bit clears
`timescale 1ns/1ps
module bcfg_discharge
  import bcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  bcfg_dis_if.dis dis
);
  bcfg_dis_state_e state_q, state_d;
  logic en_prev_q, en_prev_d;
  logic active_q, active_d;

  always_comb begin
    en_prev_d = dis.reg_enable;
    state_d = state_q;
    case (state_q)
      BCFG_DIS_IDLE: begin
        if (dis.discharge_en && en_prev_q && !dis.reg_enable) begin
          state_d = BCFG_DIS_ACTIVE;
        end
      end
      BCFG_DIS_ACTIVE: begin
        if (!dis.discharge_en || dis.reg_enable) begin
          state_d = BCFG_DIS_IDLE;
        end
      end
      default: begin
        state_d = BCFG_DIS_IDLE;
      end
    endcase
    // Off whenever the enable bit is clear
    active_d = dis.discharge_en && ((state_d == BCFG_DIS_ACTIVE) || dis.vout_falling);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= BCFG_DIS_IDLE;
      en_prev_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      en_prev_q <= en_prev_d;
      active_q <= active_d;
    end
  end

  assign dis.pulldown_active = active_q;
endmodule : bcfg_discharge

/* File: logic/bcfg_regs.sv */
// Purpose: Current-limit, output discharge and defaults-restore registers
// Assumes: Serial engine presents decoded byte accesses synchronous to the clock
// Notes: Regulation enable bit lives in another register and arrives as an input
// Notes: A restore write overrides any setting written in the same cycle
// Notes: Read data holds the last word read until the next read strobe

// What this block does
// - A four-bit read/write current-limit code sits in bits 3:0 of register 0x05 and resets to 1111.
// - The code sets a peak current threshold of 530 mA plus 108 mA per step, 2150 mA at 1111.
// - With discharge bit 2 set the pull-down turns on at an enable fall and on falling output, else it stays off.
// - A two-bit strength select, reset 00, picks open, 200, 100 or 50 ohms.
// - Writing 0x60 to write-only register 0x07 restores all settings to defaults; other values do nothing.
// - The regulation enable bit shuts the regulator down at 0, regulates at 1, and its fall triggers discharge.

`timescale 1ns/1ps
module bcfg_regs
  import bcfg_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_REG_ENABLE,
  input wire logic I_VOUT_FALLING,
  output logic [7:0] O_RDATA,
  output logic [3:0] O_PEAK_CURRENT_CODE,
  output logic [11:0] O_CURRENT_LIMIT_MA,
  output logic O_REGULATE,
  output logic O_PULLDOWN_EN,
  output logic [1:0] O_PULLDOWN_SEL,
  output logic O_PULLDOWN_ACTIVE,
  output logic [1:0] O_PULLDOWN_STRENGTH
);
  // Settings held for the power stage
  logic [3:0] code_q;
  logic [3:0] code_d;
  logic dis_en_q;
  logic dis_en_d;
  logic [1:0] dis_sel_q;
  logic [1:0] dis_sel_d;
  // Last read-back word
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  // Drive toward the power stage
  logic [11:0] ma_q;
  logic [11:0] ma_d;
  logic regulate_q;
  logic regulate_d;
  // Applied pull-down leg
  logic [1:0] strength_q;
  logic [1:0] strength_d;
  // Decoded write strobes and fields
  logic restore;
  logic wr_thresh;
  logic wr_discharge;
  logic [3:0] wr_code;
  logic wr_dis_en;
  logic [1:0] wr_dis_sel;

  bcfg_dis_if dis_bus ();

  // Threshold in mA for one code
  function automatic logic [11:0] code_to_ma(input logic [3:0] code);
    code_to_ma = 12'(BCFG_PEAK_CURRENT_CODE_BASE_MA + BCFG_PEAK_CURRENT_CODE_STEP_MA * {8'h00, code});
  endfunction : code_to_ma

  // Strobe aimed at one register offset
  function automatic logic hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = strobe && (addr == ofs);
  endfunction : hit

  // Read-back word; unused bits and the key register read zero
  function automatic logic [7:0] read_word(
    input logic [7:0] addr,
    input logic [3:0] code,
    input logic en,
    input logic [1:0] sel
  );
    case (addr)
      BCFG_OFS_CUR_THRESH: begin
        read_word = {4'h0, code};
      end
      BCFG_OFS_DISCHARGE: begin
        read_word = {5'h00, en, sel};
      end
      BCFG_OFS_RESTORE: begin
        read_word = 8'h00;
      end
      default: begin
        read_word = 8'h00;
      end
    endcase
  endfunction : read_word

  // Leg applied to the output; open while the pull-down is idle
  function automatic logic [1:0] applied_strength(
    input logic active,
    input logic [1:0] sel
  );
    if (!active) begin
      applied_strength = BCFG_SEL_OPEN;
    end else begin
      case (sel)
        BCFG_SEL_200_OHM: begin
          applied_strength = BCFG_SEL_200_OHM;
        end
        BCFG_SEL_100_OHM: begin
          applied_strength = BCFG_SEL_100_OHM;
        end
        BCFG_SEL_50_OHM: begin
          applied_strength = BCFG_SEL_50_OHM;
        end
        default: begin
          applied_strength = BCFG_SEL_OPEN;
        end
      endcase
    end
  endfunction : applied_strength

  // Upper bits of the byte are dropped here
  always_comb begin
    restore = hit(I_WR, I_ADDR, BCFG_OFS_RESTORE) && (I_WDATA == BCFG_RESTORE_KEY);
    wr_thresh = hit(I_WR, I_ADDR, BCFG_OFS_CUR_THRESH);
    wr_discharge = hit(I_WR, I_ADDR, BCFG_OFS_DISCHARGE);
    wr_code = I_WDATA[BCFG_CODE_LSB +: 4];
    wr_dis_en = I_WDATA[BCFG_DIS_EN_BIT];
    wr_dis_sel = I_WDATA[BCFG_DIS_SEL_LSB +: 2];
  end

  // Restore wins over any other write
  always_comb begin
    code_d = code_q;
    dis_en_d = dis_en_q;
    dis_sel_d = dis_sel_q;
    if (restore) begin
      code_d = BCFG_RST_CODE;
      dis_en_d = BCFG_RST_DIS_EN;
      dis_sel_d = BCFG_RST_DIS_SEL;
    end else if (wr_thresh) begin
      code_d = wr_code;
    end else if (wr_discharge) begin
      dis_en_d = wr_dis_en;
      dis_sel_d = wr_dis_sel;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      code_q <= BCFG_RST_CODE;
      dis_en_q <= BCFG_RST_DIS_EN;
      dis_sel_q <= BCFG_RST_DIS_SEL;
    end else begin
      code_q <= code_d;
      dis_en_q <= dis_en_d;
      dis_sel_q <= dis_sel_d;
    end
  end

  // Read data holds until the next read strobe
  always_comb begin
    if (I_RD) begin
      rdata_d = read_word(I_ADDR, code_q, dis_en_q, dis_sel_q);
    end else begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= BCFG_RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // One cycle behind the settings they follow
  always_comb begin
    ma_d = code_to_ma(code_q);
    regulate_d = I_REG_ENABLE;
    strength_d = applied_strength(dis_bus.pulldown_active, dis_sel_q);
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ma_q <= BCFG_RST_MA;
      regulate_q <= BCFG_RST_REGULATE;
      strength_q <= BCFG_SEL_OPEN;
    end else begin
      ma_q <= ma_d;
      regulate_q <= regulate_d;
      strength_q <= strength_d;
    end
  end

  // Discharge control sees the enable bit and the live regulation enable
  assign dis_bus.discharge_en = dis_en_q;
  assign dis_bus.reg_enable = I_REG_ENABLE;
  assign dis_bus.vout_falling = I_VOUT_FALLING;

  // Pull-down sequencing lives in its own module
  bcfg_discharge u_discharge (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .dis(dis_bus)
  );

  // Outputs straight from registers
  assign O_RDATA = rdata_q;
  assign O_PEAK_CURRENT_CODE = code_q;
  assign O_CURRENT_LIMIT_MA = ma_q;
  assign O_REGULATE = regulate_q;
  assign O_PULLDOWN_EN = dis_en_q;
  assign O_PULLDOWN_SEL = dis_sel_q;
  assign O_PULLDOWN_ACTIVE = dis_bus.pulldown_active;
  assign O_PULLDOWN_STRENGTH = strength_q;
endmodule : bcfg_regs

/* File: tb/bcfg_regs_assertions.sv */
// Purpose: Port checks for the config bank
// Assumes: One clock domain
// Notes: Bound in the bench top
`timescale 1ns/1ps
module bcfg_regs_assertions (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_REG_ENABLE,
  input wire logic [7:0] O_RDATA,
  input wire logic [3:0] O_PEAK_CURRENT_CODE,
  input wire logic [11:0] O_CURRENT_LIMIT_MA,
  input wire logic O_REGULATE,
  input wire logic O_PULLDOWN_EN,
  input wire logic [1:0] O_PULLDOWN_SEL,
  input wire logic O_PULLDOWN_ACTIVE,
  input wire logic [1:0] O_PULLDOWN_STRENGTH
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  property p_code; I_WR && I_ADDR == 8'h05 |=> O_PEAK_CURRENT_CODE == $past(I_WDATA[3:0]); endproperty
  a_code: assert property (p_code) else $error("code");
  property p_ma; 1'b1 |=> O_CURRENT_LIMIT_MA == 12'd530 + 12'd108 * $past(O_PEAK_CURRENT_CODE); endproperty
  a_ma: assert property (p_ma) else $error("limit");
  property p_fall; O_PULLDOWN_EN && !I_WR && $fell(I_REG_ENABLE) |-> ##[1:2] O_PULLDOWN_ACTIVE; endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_off; !O_PULLDOWN_EN |=> !O_PULLDOWN_ACTIVE; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_str; 1'b1 |=> O_PULLDOWN_STRENGTH == ($past(O_PULLDOWN_ACTIVE) ? $past(O_PULLDOWN_SEL) : 2'h0); endproperty
  a_str: assert property (p_str) else $error("strength");
  property p_rst; I_WR && I_ADDR == 8'h07 && I_WDATA == 8'h60 |=> O_PEAK_CURRENT_CODE == 4'hf && !O_PULLDOWN_EN; endproperty
  a_rst: assert property (p_rst) else $error("restore");
  property p_reg; 1'b1 |=> O_REGULATE == $past(I_REG_ENABLE); endproperty
  a_reg: assert property (p_reg) else $error("regulate");
  property p_rd7; I_RD && I_ADDR == 8'h07 |=> O_RDATA == 8'h00; endproperty
  a_rd7: assert property (p_rd7) else $error("read 07");
endmodule : bcfg_regs_assertions

/* File: tb/bcfg_host.sv */
// Purpose: Host model for byte accesses
// Assumes: One strobe per access
// Notes: Data inverted when idle
`timescale 1ns/1ps
module bcfg_host (
  input wire logic i_clk,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
  endtask : acc
endmodule : bcfg_host

/* File: tb/tb_buck_regulator_config_regs.sv */
// Purpose: Self-checking bench for the config bank
// Assumes: Fixed seed
// Notes: Host model drives the byte port
`timescale 1ns/1ps
module tb_buck_regulator_config_regs;
  logic I_CLOCK = 1'b0, I_RST_N = 1'b0, I_REG_ENABLE = 1'b0, I_VOUT_FALLING = 1'b0;
  logic I_WR, I_RD, O_REGULATE, O_PULLDOWN_EN, O_PULLDOWN_ACTIVE;
  logic [7:0] I_ADDR, I_WDATA, O_RDATA, d;
  logic [3:0] O_PEAK_CURRENT_CODE;
  logic [11:0] O_CURRENT_LIMIT_MA;
  logic [1:0] O_PULLDOWN_SEL, O_PULLDOWN_STRENGTH;
  integer seed = 99580;
  int failures = 0;
  int tests_run = 0;
  always #4 I_CLOCK = ~I_CLOCK;
  bcfg_host host (.i_clk(I_CLOCK), .o_wr(I_WR), .o_rd(I_RD), .o_addr(I_ADDR), .o_wdata(I_WDATA));
  bcfg_regs dut (
    .I_CLOCK(I_CLOCK),
    .I_RST_N(I_RST_N),
    .I_WR(I_WR),
    .I_RD(I_RD),
    .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA),
    .I_REG_ENABLE(I_REG_ENABLE),
    .I_VOUT_FALLING(I_VOUT_FALLING),
    .O_RDATA(O_RDATA),
    .O_PEAK_CURRENT_CODE(O_PEAK_CURRENT_CODE),
    .O_CURRENT_LIMIT_MA(O_CURRENT_LIMIT_MA),
    .O_REGULATE(O_REGULATE),
    .O_PULLDOWN_EN(O_PULLDOWN_EN),
    .O_PULLDOWN_SEL(O_PULLDOWN_SEL),
    .O_PULLDOWN_ACTIVE(O_PULLDOWN_ACTIVE),
    .O_PULLDOWN_STRENGTH(O_PULLDOWN_STRENGTH)
  );
  // Threshold in mA that a code should select
  function automatic logic [11:0] exp_ma(input logic [3:0] code);
    exp_ma = 12'd530 + 12'd108 * {8'h00, code};
  endfunction : exp_ma
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.acc(1'b0, a, 8'h00);
    #1 chk({4'h0, O_RDATA}, {4'h0, exp});
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge I_CLOCK);
    #1;
  endtask : step
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    rdc(8'h05, 8'h0f);
    rdc(8'h06, 8'h00);
    chk(O_CURRENT_LIMIT_MA, 12'd2150);
    $display("reset done");
    for (int i = 0; i < 20; i++) begin
      d = i == 0 ? 8'hf0 : 8'($random(seed));
      host.acc(1'b1, 8'h05, d);
      rdc(8'h05, {4'h0, d[3:0]});
      chk(O_PEAK_CURRENT_CODE, d[3:0]);
      chk(O_CURRENT_LIMIT_MA, exp_ma(d[3:0]));
    end
    $display("limit done");
    for (int s = 0; s < 4; s++) begin
      d = 8'($random(seed));
      d[2:0] = {1'b1, s[1:0]};
      host.acc(1'b1, 8'h06, d);
      rdc(8'h06, {5'h00, d[2:0]});
      chk(O_PULLDOWN_EN, 1'b1);
      chk(O_PULLDOWN_SEL, s[1:0]);
      @(posedge I_CLOCK) I_REG_ENABLE <= 1'b1;
      @(posedge I_CLOCK) I_REG_ENABLE <= 1'b0;
      step(3);
      chk(O_PULLDOWN_ACTIVE, 1'b1);
      chk(O_PULLDOWN_STRENGTH, s[1:0]);
      chk(O_REGULATE, 1'b0);
      @(posedge I_CLOCK) I_REG_ENABLE <= 1'b1;
      step(3);
      chk(O_PULLDOWN_ACTIVE, 1'b0);
      chk(O_REGULATE, 1'b1);
    end
    @(posedge I_CLOCK) I_VOUT_FALLING <= 1'b1;
    step(3);
    chk(O_PULLDOWN_ACTIVE, 1'b1);
    host.acc(1'b1, 8'h06, 8'h03);
    step(2);
    chk(O_PULLDOWN_ACTIVE, 1'b0);
    @(posedge I_CLOCK) I_VOUT_FALLING <= 1'b0;
    $display("discharge done");
    host.acc(1'b1, 8'h05, 8'h03);
    host.acc(1'b1, 8'h07, 8'h61);
    rdc(8'h06, 8'h03);
    rdc(8'h05, 8'h03);
    host.acc(1'b1, 8'h07, 8'h60);
    rdc(8'h05, 8'h0f);
    rdc(8'h06, 8'h00);
    chk(O_CURRENT_LIMIT_MA, exp_ma(4'hf));
    chk(O_PULLDOWN_SEL, 2'h0);
    rdc(8'h07, 8'h00);
    rdc(8'h09, 8'h00);
    $display("restore done");
    give_verdict();
  end
  // Run needs about 175 cycles; the limit allows 12500
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule : tb_buck_regulator_config_regs
bind bcfg_regs bcfg_regs_assertions u_chk (
  .I_CLOCK(I_CLOCK),
  .I_RST_N(I_RST_N),
  .I_WR(I_WR),
  .I_RD(I_RD),
  .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA),
  .I_REG_ENABLE(I_REG_ENABLE),
  .O_RDATA(O_RDATA),
  .O_PEAK_CURRENT_CODE(O_PEAK_CURRENT_CODE),
  .O_CURRENT_LIMIT_MA(O_CURRENT_LIMIT_MA),
  .O_REGULATE(O_REGULATE),
  .O_PULLDOWN_EN(O_PULLDOWN_EN),
  .O_PULLDOWN_SEL(O_PULLDOWN_SEL),
  .O_PULLDOWN_ACTIVE(O_PULLDOWN_ACTIVE),
  .O_PULLDOWN_STRENGTH(O_PULLDOWN_STRENGTH)
);
